// File: hdl/field_codec_pkg.sv
// Constants and types shared by the datagram field encoder files
package field_codec_pkg;
	localparam int BYTE_W      = 8;
	localparam int PPS_W       = 24;
	localparam int TEMP_W      = 16;
	localparam int COUNT_W     = 16;
	localparam int TIME_IN_W   = 32;
	localparam int FRAME_W     = 88;
	localparam int FIFO_DEPTH  = 8;
	localparam int FIFO_W      = BYTE_W + 1;
	localparam int LEFT_W      = 4;
	// Byte counts per field group
	localparam logic [LEFT_W-1:0] PPS_BYTES   = 4'h3;
	localparam logic [LEFT_W-1:0] TEMP_BYTES  = 4'h6;
	localparam logic [LEFT_W-1:0] CNT_BYTES_1 = 4'h1;
	localparam logic [LEFT_W-1:0] CNT_BYTES_2 = 4'h2;
	// Filtered value 1.0 with 22 fractional bits
	localparam logic [PPS_W-1:0] FILT_ONE = 24'h400000;
	// 24-bit signed limits for microsecond count
	localparam logic signed [TIME_IN_W-1:0] TIME_MAX = 32'sh007FFFFF;
	localparam logic signed [TIME_IN_W-1:0] TIME_MIN = -32'sh00800000;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;

	typedef enum logic {
		PPS_UNIT_TIME = 1'b0,
		PPS_UNIT_FILT = 1'b1
	} pps_unit_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SEND = 2'b10
	} enc_state_t;
endpackage : field_codec_pkg

// File: hdl/stream_if.sv
// Valid/ready word stream between the encoder and its FIFO
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int W = 9);
	logic [W-1:0] data;
	logic         valid;
	logic         ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : stream_if
`default_nettype wire

// File: hdl/byte_fifo.sv
// Parameterised FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic reset,
	// Filling side
	stream_if.snk     inPort,
	// Draining side
	stream_if.src     outPort
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_r;
	logic [AW-1:0]    rdPtr_r;
	logic [AW:0]      count_r;
	logic [WIDTH-1:0] outData_r;
	logic             outValid_r;
	logic             push;
	logic             pop;

	// Ready only while a slot is free, so back-pressure reaches the source
	assign inPort.ready  = (count_r != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign push          = inPort.valid && inPort.ready;
	assign pop           = (count_r != '0) && (!outValid_r || outPort.ready);
	assign outPort.data  = outData_r;
	assign outPort.valid = outValid_r;

	always_ff @(posedge clock) begin
		if (push)
			mem[wrPtr_r] <= inPort.data;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			if (push)
				wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
			if (pop)
				rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
			if (push && !pop)
				count_r <= count_r + 1'b1;
			else if (pop && !push)
				count_r <= count_r - 1'b1;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			outData_r  <= '0;
			outValid_r <= 1'b0;
		end else if (pop) begin
			outData_r  <= mem[rdPtr_r];
			outValid_r <= 1'b1;
		end else if (outPort.ready) begin
			outValid_r <= 1'b0;
		end
	end
endmodule : byte_fifo
`default_nettype wire

// File: hdl/imu_datagram_field_codec.sv
// Encoder for the pulse, temperature and counter fields of a datagram
//
// Overview of operation
// - Each 24-bit pulse field leaves as three bytes, most significant first.
// - In time mode the field is a signed microsecond count, bit 23 the sign.
// - In filtered mode the field is unsigned, LSB 2^-22, held within 0..1.
// - Temperature is 16-bit signed with 8 fraction bits, high byte first.
// - One temperature per axis, sent only when the datagram carries them.
// - The sample counter is unsigned, one or two bytes by datagram type.
// - A two-byte counter goes high byte first, value = first*256 + second.
`timescale 1ns/1ps
`default_nettype none
module imu_datagram_field_codec (
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 reset,
	// Sample request
	input  wire logic                 sampleValid,
	output logic                      sampleReady,
	input  wire logic                 ppsUnit,
	input  wire logic signed [31:0]   ppsTimeUs,
	input  wire logic [23:0]          ppsFiltered,
	input  wire logic                 tempPresent,
	input  wire logic [15:0]          tempX,
	input  wire logic [15:0]          tempY,
	input  wire logic [15:0]          tempZ,
	input  wire logic                 counterWide,
	// Byte stream out
	output logic [7:0]                byteData,
	output logic                      byteValid,
	output logic                      byteLast,
	input  wire logic                 byteReady,
	// Status
	output logic [15:0]               sampleCount
);
	localparam int BW = field_codec_pkg::BYTE_W;
	localparam int FW = field_codec_pkg::FRAME_W;
	localparam int LW = field_codec_pkg::LEFT_W;

	field_codec_pkg::enc_state_t state_r;
	logic [FW-1:0]                        frame_r;
	logic [FW-1:0]                        frame_nxt;
	logic [LW-1:0]                        left_r;
	logic [LW-1:0]                        left_nxt;
	logic [field_codec_pkg::COUNT_W-1:0]  count_r;
	logic [field_codec_pkg::PPS_W-1:0]    ppsField;
	logic                                 accept;
	logic                                 pushByte;

	stream_if #(.W(field_codec_pkg::FIFO_W)) encIf ();
	stream_if #(.W(field_codec_pkg::FIFO_W)) outIf ();

	assign accept   = sampleValid && (state_r == field_codec_pkg::ST_IDLE);
	assign pushByte = encIf.valid && encIf.ready;

	// Pulse field encoding chosen by the configured unit
	always_comb begin
		if (ppsUnit == field_codec_pkg::PPS_UNIT_FILT) begin
			// Values above 1.0 are clipped to stay inside the legal range
			if (ppsFiltered > field_codec_pkg::FILT_ONE)
				ppsField = field_codec_pkg::FILT_ONE;
			else
				ppsField = ppsFiltered;
		end else begin
			// Saturate rather than wrap so the sign stays meaningful
			if (ppsTimeUs > field_codec_pkg::TIME_MAX)
				ppsField = field_codec_pkg::TIME_MAX[23:0];
			else if (ppsTimeUs < field_codec_pkg::TIME_MIN)
				ppsField = field_codec_pkg::TIME_MIN[23:0];
			else
				ppsField = ppsTimeUs[23:0];
		end
	end

	// Pack bytes left aligned so the frame shifts out from its top
	always_comb begin
		if (tempPresent) begin
			left_nxt = field_codec_pkg::PPS_BYTES + field_codec_pkg::TEMP_BYTES;
			if (counterWide)
				frame_nxt = {ppsField, tempX, tempY, tempZ,
					count_r};
			else
				frame_nxt = {ppsField, tempX, tempY, tempZ, count_r[7:0],
					8'h00};
		end else begin
			left_nxt = field_codec_pkg::PPS_BYTES;
			if (counterWide)
				frame_nxt = {ppsField, count_r, 48'h000000000000};
			else
				frame_nxt = {ppsField, count_r[7:0], 56'h00000000000000};
		end
		if (counterWide)
			left_nxt = left_nxt + field_codec_pkg::CNT_BYTES_2;
		else
			left_nxt = left_nxt + field_codec_pkg::CNT_BYTES_1;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_r <= field_codec_pkg::ST_IDLE;
		end else begin
			case (state_r)
				field_codec_pkg::ST_IDLE: begin
					if (accept)
						state_r <= field_codec_pkg::ST_SEND;
				end
				field_codec_pkg::ST_SEND: begin
					if (pushByte && left_r == LW'(1))
						state_r <= field_codec_pkg::ST_IDLE;
				end
				default: state_r <= field_codec_pkg::ST_IDLE;
			endcase
		end
	end

	// Shift out top byte first for every multi-byte field
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			frame_r <= '0;
			left_r  <= '0;
		end else if (accept) begin
			frame_r <= frame_nxt;
			left_r  <= left_nxt;
		end else if (pushByte) begin
			frame_r <= {frame_r[FW-BW-1:0], 8'h00};
			left_r  <= left_r - 1'b1;
		end
	end

	// Counter wraps through zero with no flag
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			count_r <= field_codec_pkg::COUNT_RESET;
		else if (accept)
			count_r <= count_r + 1'b1;
	end

	assign encIf.valid = (state_r == field_codec_pkg::ST_SEND);
	assign encIf.data  = {(left_r == LW'(1)), frame_r[FW-1:FW-BW]};

	byte_fifo #(
		.WIDTH (field_codec_pkg::FIFO_W),
		.DEPTH (field_codec_pkg::FIFO_DEPTH)
	) fifoInst (
		.clock   (clock),
		.reset   (reset),
		.inPort  (encIf),
		.outPort (outIf)
	);

	assign outIf.ready = byteReady;
	assign byteData    = outIf.data[BW-1:0];
	assign byteLast    = outIf.data[BW];
	assign byteValid   = outIf.valid;
	assign sampleReady = state_r[0];
	assign sampleCount = count_r;
endmodule : imu_datagram_field_codec
`default_nettype wire

// File: testbench/imu_datagram_field_codec_chk.sv
// Assertions on the field encoder ports
`timescale 1ns/1ps
`default_nettype none
module imu_datagram_field_codec_chk (
	// Clock and reset
	input wire logic        clock,
	input wire logic        reset,
	// Watched ports
	input wire logic        sampleValid,
	input wire logic        sampleReady,
	input wire logic [7:0]  byteData,
	input wire logic        byteValid,
	input wire logic        byteLast,
	input wire logic        byteReady,
	input wire logic [15:0] sampleCount
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	sequence take_s; sampleValid && sampleReady; endsequence
	sequence stall_s; byteValid && !byteReady; endsequence
	count_incr_a: assert property (take_s |=>
		sampleCount == $past(sampleCount) + 16'h0001) else $error("count step");
	count_hold_a: assert property (!(sampleValid && sampleReady) |=>
		$stable(sampleCount)) else $error("count moved");
	busy_min_a: assert property (take_s |=> !sampleReady [*3])
		else $error("ready too early");
	first_byte_a: assert property (take_s |-> ##[1:3] byteValid)
		else $error("no byte");
	valid_hold_a: assert property (stall_s |=> byteValid)
		else $error("byte dropped");
	data_hold_a: assert property (stall_s |=> $stable(byteData))
		else $error("byte changed");
	last_hold_a: assert property (stall_s |=> $stable(byteLast))
		else $error("last changed");
	reset_state_a: assert property (disable iff (1'b0) reset |->
		sampleCount == 16'h0000 && !byteValid) else $error("reset state");
endmodule : imu_datagram_field_codec_chk
bind imu_datagram_field_codec imu_datagram_field_codec_chk chk_u (.clock,
	.reset, .sampleValid, .sampleReady, .byteData, .byteValid, .byteLast,
	.byteReady, .sampleCount);
`default_nettype wire

// File: testbench/host_sink.sv
// Host side byte sink that records what it takes
`timescale 1ns/1ps
`default_nettype none
module host_sink (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	// Byte stream
	input  wire logic [7:0] byteData,
	input  wire logic       byteValid,
	input  wire logic       byteLast,
	output logic            byteReady,
	// Bench control
	input  wire logic       stall
);
	logic [8:0] got[$];
	assign byteReady = !stall;
	always @(posedge clock) begin
		if (reset) got = {};
		else if (byteValid && byteReady) got.push_back({byteLast, byteData});
	end
endmodule : host_sink
`default_nettype wire

// File: testbench/imu_datagram_field_codec_tb.sv
// Bench for the datagram field encoder
`timescale 1ns/1ps
`default_nettype none
module imu_datagram_field_codec_tb;
	typedef struct {
		logic        unit;
		logic [31:0] timeUs;
		logic [23:0] filt;
		logic        temp;
		logic        wide;
		logic [23:0] pps;
	} row_t;
	row_t rows[5] = '{
		'{1'b0, 32'hFFFFFFFB, 24'h000000, 1'b0, 1'b0, 24'hFFFFFB},
		'{1'b0, 32'h01000000, 24'h000000, 1'b1, 1'b1, 24'h7FFFFF},
		'{1'b0, 32'hFF700000, 24'h000000, 1'b0, 1'b1, 24'h800000},
		'{1'b1, 32'h00000000, 24'h500000, 1'b1, 1'b0, 24'h400000},
		'{1'b1, 32'h00000000, 24'h123456, 1'b0, 1'b1, 24'h123456}};
	logic        clock, reset, sampleValid, sampleReady, ppsUnit, stall;
	logic        tempPresent, counterWide, byteValid, byteLast, byteReady;
	logic [31:0] ppsTimeUs;
	logic [23:0] ppsFiltered;
	logic [15:0] tempX = 16'hFE80, tempY = 16'h1940, tempZ = 16'h8000;
	logic [15:0] sampleCount, expCount;
	logic [7:0]  byteData;
	int          fail_count = 0, checks = 0;
	imu_datagram_field_codec dut_u (
		.clock       (clock),
		.reset       (reset),
		.sampleValid (sampleValid),
		.sampleReady (sampleReady),
		.ppsUnit     (ppsUnit),
		.ppsTimeUs   (ppsTimeUs),
		.ppsFiltered (ppsFiltered),
		.tempPresent (tempPresent),
		.tempX       (tempX),
		.tempY       (tempY),
		.tempZ       (tempZ),
		.counterWide (counterWide),
		.byteData    (byteData),
		.byteValid   (byteValid),
		.byteLast    (byteLast),
		.byteReady   (byteReady),
		.sampleCount (sampleCount)
	);
	host_sink sink_u (
		.clock     (clock),
		.reset     (reset),
		.byteData  (byteData),
		.byteValid (byteValid),
		.byteLast  (byteLast),
		.byteReady (byteReady),
		.stall     (stall)
	);
	always #4 clock = ~clock;
	task automatic check(input string what, input logic [15:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic send(input row_t r);
		logic [7:0] e[$];
		logic [8:0] g[$];
		logic [8:0] w;
		int n;
		e = {r.pps[23:16], r.pps[15:8], r.pps[7:0]};
		if (r.temp) e = {e, tempX[15:8], tempX[7:0], tempY[15:8], tempY[7:0],
			tempZ[15:8], tempZ[7:0]};
		if (r.wide) e.push_back(expCount[15:8]);
		e.push_back(expCount[7:0]);
		sink_u.got = {};
		@(negedge clock);
		ppsUnit = r.unit;
		ppsTimeUs = r.timeUs;
		ppsFiltered = r.filt;
		tempPresent = r.temp;
		counterWide = r.wide;
		sampleValid = 1'b1;
		for (n = 0; sampleReady !== 1'b1 && n < 50; n++) @(negedge clock);
		@(negedge clock);
		sampleValid = 1'b0;
		expCount++;
		check("count", sampleCount, expCount);
		for (n = 0; sink_u.got.size() < e.size() && n < 200; n++)
			@(negedge clock);
		repeat (3) @(negedge clock);
		check("length", sink_u.got.size(), e.size());
		g = sink_u.got;
		foreach (e[i]) begin
			w = {i == e.size() - 1, e[i]};
			check("byte", g[i], w);
		end
	endtask : send
	task automatic final_report;
		if (fail_count == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report
	initial begin
		#200000;
		fail_count++;
		final_report();
	end
	initial begin
		{clock, sampleValid, ppsUnit, ppsTimeUs, ppsFiltered} = '0;
		{tempPresent, counterWide, stall, expCount} = '0;
		reset = 1'b1;
		repeat (3) @(negedge clock);
		reset = 1'b0;
		foreach (rows[i]) send(rows[i]);
		// Eleven bytes fill the FIFO and back-pressure the encoder while the host stalls
		stall = 1'b1;
		fork
			send(rows[1]);
			begin
				repeat (30) @(negedge clock);
				stall = 1'b0;
			end
		join
		// Narrow counter wraps past 255
		repeat (256) send(rows[0]);
		// Wide counter now has a nonzero high byte
		send(rows[2]);
		stall = 1'b1;
		sampleValid = 1'b1;
		repeat (4) @(negedge clock);
		reset = 1'b1;
		@(negedge clock);
		check("ready", sampleReady, 16'h0001);
		check("valid", byteValid, 16'h0000);
		check("count", sampleCount, 16'h0000);
		{reset, stall, sampleValid, expCount} = '0;
		send(rows[3]);
		final_report();
	end
endmodule : imu_datagram_field_codec_tb
`default_nettype wire
